// File: logic/hk_mux.sv
/*
 * Housekeeping and status multiplexer feeding channel A.
 * Assumes pps and minor frame ticks are one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
module hk_mux
	import tlm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	hk_if.hk port
);
	logic [HK_W-1:0] pos_ff;
	logic [7:0] word_ff;
	logic load_ff;
	logic [HK_W-1:0] sel;

	// The pps cycle is the frame boundary, so a minor frame tick in it is not counted.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_ff <= 4'h0;
		end else if (port.pps_tick) begin
			pos_ff <= 4'h0;
		end else if (port.mfm_tick) begin
			pos_ff <= pos_ff + 4'h1;
		end
	end

	assign sel = port.pps_tick ? 4'h0 : (port.mfm_tick ? pos_ff + 4'h1 : pos_ff);

	// The converter result is presented in parallel; the formatter shifts it out.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			word_ff <= 8'h00;
			load_ff <= 1'b0;
		end else begin
			load_ff <= port.pps_tick | port.mfm_tick;
			if (port.pps_tick | port.mfm_tick) begin
				if (sel <= HK_LAST_STATUS) begin
					word_ff <= port.status_bits[sel[1:0]*8 +: 8];
				end else if (sel == HK_SPARE) begin
					word_ff <= 8'h00;
				end else begin
					word_ff <= port.adc_sample[ADC_W-1 -: 8];
				end
			end
		end
	end

	assign port.position = pos_ff;
	assign port.word = word_ff;
	assign port.load = load_ff;
endmodule

// File: logic/sweep_mem.sv
/*
 * Sweep memory of 32 words by 24 bits with one write and one registered read.
 * Assumes the caller issues reads as one-cycle strobes.
 */
`timescale 1ns/1ps
module sweep_mem
	import tlm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	mem_if.mem port
);
	logic [MEM_W-1:0] store [MEM_DEPTH];
	logic [MEM_W-1:0] rdata_ff;

	always_ff @(posedge clk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 24'h000000;
		end else if (port.re) begin
			rdata_ff <= store[port.raddr];
		end
	end

	assign port.rdata = rdata_ff;
endmodule

// File: logic/tlm_if.sv
/*
 * Interfaces between the selector and its two helpers: the sweep memory port
 * and the housekeeping frame port. All signals live on the one system clock.
 */
`timescale 1ns/1ps
interface mem_if;
	logic we;
	logic [4:0] waddr;
	logic [23:0] wdata;
	logic re;
	logic [4:0] raddr;
	logic [23:0] rdata;
	modport ctl (output we, output waddr, output wdata, output re, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface

interface hk_if;
	logic pps_tick;
	logic mfm_tick;
	logic [31:0] status_bits;
	logic [11:0] adc_sample;
	logic [3:0] position;
	logic [7:0] word;
	logic load;
	modport ctl (output pps_tick, output mfm_tick, output status_bits, output adc_sample,
		input position, input word, input load);
	modport hk (input pps_tick, input mfm_tick, input status_bits, input adc_sample,
		output position, output word, output load);
endinterface

// File: logic/tlm_mode_selector.sv
/*
 * Telemetry mode selector: resolves the instrument mode, routes data words into
 * channels B to F, sequences memory dumps and drives the sweep memory outputs.
 * Assumes an AHB-Lite master, asynchronous frame pulses on pins and data words
 * from accumulator logic on the same clock, stable at each quarter frame pulse.
 */
// Functional notes
// - Mode priority: load, dump, retarding, cyclic, mass.
// - First load word sets memory load flag.
// - Calibrate bit asserted while memory load active.
// - Load: B-E calibration, F background counts.
// - Dump shows address zero from next pps.
// - Dump takes F only; B-E follow mode.
// - Read each quarter, advance per frame mark.
// - No pps address reset during dump.
// - Automatic dump every 256 seconds.
// - Retarding mode keeps Z mass words out.
// - Retarding: D plus-Z, E minus-Z, F radial.
// - Cyclic code in initial head bits selects cyclic.
// - Cyclic sets: radial/Z1Z3, plusZ/Z1Z2, minusZ/Z3Z4.
// - Each cyclic step lasts toggle-rate frames.
// - Mass scan default; B,C radial, D,E pairs.
// - Housekeeping counter cleared at pps, counts frames.
// - Positions one to four give status bytes.
// - Monitor positions give converter's eight MSBs.
// - Position sixteen always reads zero.
// - Memory holds 32 words of 24 bits.
// - Memory usage field selects sweep source.
// - Toggle rate 8,4,2,1 frames, pps aligned.
// - Mode A settings load only at pps.
// - Mass mode D/E alternate initial/alternate pairs.
`timescale 1ns/1ps
module tlm_mode_selector
	import tlm_pkg::*;
#(
	parameter int AUTO_DUMP_SECONDS = AUTO_DUMP_SEC
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pps_pin,
	input wire logic mfm_pin,
	input wire logic qfr_pin,
	input wire logic [9:0] radial_low_mass_word,
	input wire logic [9:0] radial_high_mass_word,
	input wire logic [9:0] plus_z_low_mass_word,
	input wire logic [9:0] plus_z_high_mass_word,
	input wire logic [9:0] minus_z_low_mass_word,
	input wire logic [9:0] minus_z_high_mass_word,
	input wire logic [9:0] radial_retarding_word,
	input wire logic [9:0] plus_z_retarding_word,
	input wire logic [9:0] minus_z_retarding_word,
	input wire logic [9:0] background_counts,
	input wire logic [31:0] status_bits,
	input wire logic [11:0] adc_sample,
	output logic [7:0] housekeeping_status_word,
	output logic chan_a_load,
	output logic [9:0] chan_b_word,
	output logic [9:0] chan_c_word,
	output logic [9:0] chan_d_word,
	output logic [9:0] chan_e_word,
	output logic [23:0] chan_f_word,
	output logic chan_load,
	output logic calibrate,
	output logic [9:0] retarding_step,
	output logic [11:0] mass_step,
	output logic retarding_from_mem,
	output logic mass_from_mem,
	output logic [4:0] mode,
	output logic dump_active,
	output logic cyclic_active
);
	localparam logic [7:0] AUTO_LAST = 8'(AUTO_DUMP_SECONDS - 1);
	localparam logic [2:0] ALT_LAST = 3'(ALT_USE_SEC - 1);

	// Toggle rate code to the frame-counter bit that flips at that rate.
	function automatic logic alt_phase(input logic [3:0] frame, input logic [1:0] code);
		case (code)
			TGL_8: alt_phase = frame[3];
			TGL_4: alt_phase = frame[2];
			TGL_2: alt_phase = frame[1];
			default: alt_phase = frame[0];
		endcase
	endfunction

	function automatic logic [3:0] rate_last(input logic [1:0] code);
		case (code)
			TGL_8: rate_last = 4'h7;
			TGL_4: rate_last = 4'h3;
			TGL_2: rate_last = 4'h1;
			default: rate_last = 4'h0;
		endcase
	endfunction

	// Lowest two set gates of a Z mask: the first fills D, the second E.
	function automatic logic [3:0] z_pair(input logic [3:0] mask);
		logic [1:0] first;
		logic [1:0] second;
		logic found;
		first = 2'h0;
		second = 2'h1;
		found = 1'b0;
		for (int i = 3; i >= 0; i--) begin
			if (mask[i]) begin
				second = first;
				first = 2'(i);
				found = 1'b1;
			end
		end
		if (!found) begin
			second = 2'h1;
		end
		z_pair = {first, second};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a level counts once the second and third stage agree.
	logic [2:0] sync_ff [3];
	logic [2:0] level_ff;
	logic [2:0] tick;
	logic pps_tick;
	logic mfm_tick;
	logic qfr_tick;
	logic frame_mark;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				sync_ff[i] <= 3'h0;
			end
			level_ff <= 3'h0;
		end else begin
			sync_ff[0] <= {sync_ff[0][1:0], pps_pin};
			sync_ff[1] <= {sync_ff[1][1:0], mfm_pin};
			sync_ff[2] <= {sync_ff[2][1:0], qfr_pin};
			for (int i = 0; i < 3; i++) begin
				if (sync_ff[i][1] == sync_ff[i][2]) begin
					level_ff[i] <= sync_ff[i][2];
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			tick[i] = (sync_ff[i][1] == sync_ff[i][2]) && sync_ff[i][2] && !level_ff[i];
		end
	end

	assign pps_tick = tick[0];
	assign mfm_tick = tick[1] & ~tick[0];
	assign qfr_tick = tick[2];
	// The mark hidden under the second pulse still starts a frame for dump and cyclic stepping.
	assign frame_mark = pps_tick | mfm_tick;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY, writes land in the data phase.
	logic wr_pend_ff;
	logic [7:0] wr_addr_ff;
	logic [7:0] rd_addr_ff;
	logic rd_pend_ff;
	logic [MODE_A_W-1:0] mode_a_ff;
	logic [MODE_A_W-1:0] act_ff;
	logic wr_mode_a;
	logic wr_load;
	logic wr_ctl;
	logic dump_cmd;
	logic load_clr;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			rd_addr_ff <= 8'h00;
		end else if (hready) begin
			wr_pend_ff <= hsel & htrans[1] & hwrite;
			rd_pend_ff <= hsel & htrans[1] & ~hwrite;
			wr_addr_ff <= haddr[7:0];
			rd_addr_ff <= haddr[7:0];
		end
	end

	assign wr_mode_a = wr_pend_ff && (wr_addr_ff == OFS_MODE_A);
	assign wr_load = wr_pend_ff && (wr_addr_ff == OFS_MEM_LOAD);
	assign wr_ctl = wr_pend_ff && (wr_addr_ff == OFS_CONTROL);
	assign dump_cmd = wr_ctl & hwdata[CTL_DUMP_BIT];
	assign load_clr = wr_ctl & hwdata[CTL_LOAD_CLR_BIT];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_a_ff <= MODE_A_RESET;
		end else if (wr_mode_a) begin
			mode_a_ff <= hwdata[MODE_A_W-1:0];
		end
	end

	// Settings pending in the shadow word go live only on the second boundary.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_ff <= MODE_A_RESET;
		end else if (pps_tick) begin
			act_ff <= mode_a_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Memory load: each write stores one word and raises the load flag.
	mem_if mport ();
	logic memory_load_flag_ff;
	logic [MEM_AW-1:0] load_ptr_ff;

	// A load word in the same cycle as a clear keeps the flag set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			memory_load_flag_ff <= 1'b0;
			load_ptr_ff <= 5'h00;
		end else if (wr_load) begin
			memory_load_flag_ff <= 1'b1;
			load_ptr_ff <= load_ptr_ff + 5'h01;
		end else if (load_clr) begin
			memory_load_flag_ff <= 1'b0;
			load_ptr_ff <= 5'h00;
		end
	end

	assign mport.we = wr_load;
	assign mport.waddr = load_ptr_ff;
	assign mport.wdata = hwdata[MEM_W-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Dump sequencing and the shared memory address.
	logic dump_pend_ff;
	logic dump_ff;
	logic [MEM_AW-1:0] addr_ff;
	logic [7:0] sec_ff;
	logic auto_req;
	logic dump_start;
	logic dump_end;

	assign auto_req = pps_tick && (sec_ff == AUTO_LAST);
	assign dump_start = pps_tick && dump_pend_ff && !dump_ff;
	assign dump_end = dump_ff && frame_mark && (addr_ff == 5'(MEM_DEPTH - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sec_ff <= 8'h00;
		end else if (pps_tick) begin
			sec_ff <= (sec_ff == AUTO_LAST) ? 8'h00 : sec_ff + 8'h01;
		end
	end

	// A new request in the start cycle stays pending for a later dump.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dump_pend_ff <= 1'b0;
		end else if (dump_cmd || auto_req) begin
			dump_pend_ff <= 1'b1;
		end else if (dump_start) begin
			dump_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dump_ff <= 1'b0;
		end else if (dump_start) begin
			dump_ff <= 1'b1;
		end else if (dump_end) begin
			dump_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= 5'h00;
		end else if (dump_start) begin
			addr_ff <= 5'h00;
		end else if (dump_ff) begin
			if (frame_mark) begin
				addr_ff <= addr_ff + 5'h01;
			end
		end else if (pps_tick) begin
			addr_ff <= 5'h00;
		end else if (qfr_tick) begin
			addr_ff <= addr_ff + 5'h01;
		end
	end

	assign mport.re = qfr_tick;
	// During a dump the read at a frame boundary already uses the address that the boundary selects; outside a dump the pps read uses the old address.
	assign mport.raddr = dump_start ? 5'h00 :
		((dump_ff && frame_mark) ? addr_ff + 5'h01 : addr_ff);

	sweep_mem u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.port(mport)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Frame counters, toggling and the cyclic step.
	logic [3:0] frame_ff;
	logic [1:0] step_ff;
	logic [3:0] step_cnt_ff;
	logic [2:0] alt_sec_ff;
	logic alt_use_ff;
	logic act_cyclic;

	assign act_cyclic = (act_ff[INIT_T_LSB +: 2] == T_CYCLIC) && !act_ff[DATA_MODE_BIT];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_ff <= 4'h0;
		end else if (pps_tick) begin
			frame_ff <= 4'h0;
		end else if (mfm_tick) begin
			frame_ff <= frame_ff + 4'h1;
		end
	end

	// The cycle restarts only on entry, so it drifts against the second.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_ff <= 2'h0;
			step_cnt_ff <= 4'h0;
		end else if (pps_tick && !act_cyclic) begin
			step_ff <= 2'h0;
			step_cnt_ff <= 4'h0;
		end else if (frame_mark && act_cyclic) begin
			if (step_cnt_ff >= rate_last(act_ff[TGL_LSB +: 2])) begin
				step_cnt_ff <= 4'h0;
				step_ff <= (step_ff == CYC_STEPS - 2'h1) ? 2'h0 : step_ff + 2'h1;
			end else begin
				step_cnt_ff <= step_cnt_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_sec_ff <= 3'h0;
			alt_use_ff <= 1'b0;
		end else if (pps_tick) begin
			alt_sec_ff <= (alt_sec_ff == ALT_LAST) ? 3'h0 : alt_sec_ff + 3'h1;
			if (alt_sec_ff == ALT_LAST) begin
				alt_use_ff <= ~alt_use_ff;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode resolution, latched at frame boundaries.
	mode_e mode_ff;
	mode_e base_mode;
	logic alt_ff;
	logic [MODE_A_W-1:0] nxt_act;

	// At the second pulse the settings going live decide, so a new mode owns the first frame.
	assign nxt_act = pps_tick ? mode_a_ff : act_ff;

	always_comb begin
		if (nxt_act[DATA_MODE_BIT]) begin
			base_mode = MODE_RPA;
		end else if (nxt_act[INIT_T_LSB +: 2] == T_CYCLIC) begin
			base_mode = MODE_CYCLIC;
		end else begin
			base_mode = MODE_MASS;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= MODE_MASS;
			alt_ff <= 1'b0;
		end else if (frame_mark) begin
			mode_ff <= base_mode;
			alt_ff <= pps_tick ? 1'b0 : alt_phase(frame_ff + 4'h1, act_ff[TGL_LSB +: 2]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channel routing, loaded one cycle after each quarter frame with memory data.
	logic load_stb_ff;
	logic [9:0] zw [4];
	logic [9:0] tw [3];
	logic [3:0] zsel;
	logic [1:0] tsel;
	logic [9:0] nxt_d;
	logic [9:0] nxt_e;
	logic [9:0] nxt_f;

	assign zw[0] = plus_z_low_mass_word;
	assign zw[1] = plus_z_high_mass_word;
	assign zw[2] = minus_z_low_mass_word;
	assign zw[3] = minus_z_high_mass_word;
	assign tw[0] = radial_retarding_word;
	assign tw[1] = plus_z_retarding_word;
	assign tw[2] = minus_z_retarding_word;

	always_comb begin
		zsel = z_pair(alt_ff ? act_ff[ALT_Z_LSB +: 4] : act_ff[INIT_Z_LSB +: 4]);
		tsel = alt_ff ? act_ff[ALT_T_LSB +: 2] : act_ff[INIT_T_LSB +: 2];
		if (tsel == T_CYCLIC) begin
			tsel = T_RADIAL;
		end
		nxt_d = zw[zsel[3:2]];
		nxt_e = zw[zsel[1:0]];
		nxt_f = tw[tsel];
		case (mode_ff)
			MODE_RPA: begin
				nxt_d = plus_z_retarding_word;
				nxt_e = minus_z_retarding_word;
				nxt_f = radial_retarding_word;
			end
			MODE_CYCLIC: begin
				nxt_d = (step_ff == 2'h2) ? minus_z_low_mass_word : plus_z_low_mass_word;
				nxt_e = (step_ff == 2'h0) ? minus_z_low_mass_word :
					((step_ff == 2'h1) ? plus_z_high_mass_word : minus_z_high_mass_word);
				nxt_f = tw[step_ff];
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_stb_ff <= 1'b0;
		end else begin
			load_stb_ff <= qfr_tick;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_b_word <= 10'h000;
			chan_c_word <= 10'h000;
			chan_d_word <= 10'h000;
			chan_e_word <= 10'h000;
			chan_f_word <= 24'h000000;
		end else if (load_stb_ff) begin
			chan_b_word <= radial_low_mass_word;
			chan_c_word <= radial_high_mass_word;
			chan_d_word <= nxt_d;
			chan_e_word <= nxt_e;
			if (memory_load_flag_ff) begin
				chan_f_word <= {14'h0000, background_counts};
			end else if (dump_ff) begin
				chan_f_word <= mport.rdata;
			end else begin
				chan_f_word <= {14'h0000, nxt_f};
			end
		end
	end

	// Sweep source follows the memory usage field of the live settings.
	logic [1:0] use_code;
	assign use_code = (act_ff[MEM_USE_LSB +: 2] == USE_ALT) ?
		(alt_use_ff ? USE_RET : USE_FULL) : act_ff[MEM_USE_LSB +: 2];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			retarding_step <= 10'h000;
			mass_step <= 12'h000;
			retarding_from_mem <= 1'b1;
			mass_from_mem <= 1'b1;
		end else if (load_stb_ff) begin
			retarding_step <= mport.rdata[RET_LSB +: RET_W];
			mass_step <= mport.rdata[MASS_LSB +: MASS_W];
			retarding_from_mem <= (use_code != USE_MASS);
			mass_from_mem <= (use_code != USE_RET);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Housekeeping channel and status outputs.
	hk_if hport ();
	assign hport.pps_tick = pps_tick;
	assign hport.mfm_tick = mfm_tick;
	assign hport.status_bits = status_bits;
	assign hport.adc_sample = adc_sample;

	hk_mux u_hk (
		.clk(clk),
		.rst_n(rst_n),
		.port(hport)
	);

	assign housekeeping_status_word = hport.word;
	assign chan_a_load = hport.load;
	assign chan_load = load_stb_ff;
	assign calibrate = memory_load_flag_ff;
	assign mode = memory_load_flag_ff ? MODE_LOAD : (dump_ff ? MODE_DUMP : mode_ff);
	assign dump_active = dump_ff;
	assign cyclic_active = (mode_ff == MODE_CYCLIC);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				OFS_MODE_A: hrdata <= {14'h0000, mode_a_ff};
				OFS_MODE_A_ACT: hrdata <= {14'h0000, act_ff};
				OFS_MEM_LOAD: hrdata <= {27'h0000000, load_ptr_ff};
				OFS_STATUS: hrdata <= {12'h000, hport.position, step_ff, addr_ff,
					dump_pend_ff, dump_ff, memory_load_flag_ff, 1'b0, mode};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end
endmodule

// File: logic/tlm_pkg.sv
/*
 * Shared constants for the telemetry mode selector: register offsets, command
 * word fields, sweep memory word layout, mode encodings and frame timing.
 * Assumes a 32-bit AHB-Lite register bus and 1-pps / 16-pps frame pulses.
 */
package tlm_pkg;
	localparam int WORD_W = 10;
	localparam int MEM_DEPTH = 32;
	localparam int MEM_AW = 5;
	localparam int MEM_W = 24;
	localparam int HK_W = 4;

	// Register byte offsets.
	localparam logic [7:0] OFS_MODE_A = 8'h00;
	localparam logic [7:0] OFS_MODE_A_ACT = 8'h04;
	localparam logic [7:0] OFS_MEM_LOAD = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// Minor-mode-A command word fields.
	localparam int MODE_A_W = 18;
	localparam int TGL_LSB = 0;
	localparam int INIT_T_LSB = 2;
	localparam int ALT_T_LSB = 4;
	localparam int DATA_MODE_BIT = 7;
	localparam int INIT_Z_LSB = 8;
	localparam int ALT_Z_LSB = 12;
	localparam int MEM_USE_LSB = 16;
	localparam logic [MODE_A_W-1:0] MODE_A_RESET = 18'h00000;

	// Retarding head selection codes; the last one requests cyclic mode.
	localparam logic [1:0] T_RADIAL = 2'h0;
	localparam logic [1:0] T_PLUS_Z = 2'h1;
	localparam logic [1:0] T_MINUS_Z = 2'h2;
	localparam logic [1:0] T_CYCLIC = 2'h3;

	// Toggle rate codes: 8, 4, 2, 1 minor frames.
	localparam logic [1:0] TGL_8 = 2'h0;
	localparam logic [1:0] TGL_4 = 2'h1;
	localparam logic [1:0] TGL_2 = 2'h2;
	localparam logic [1:0] TGL_1 = 2'h3;

	// Memory usage codes.
	localparam logic [1:0] USE_FULL = 2'h0;
	localparam logic [1:0] USE_MASS = 2'h1;
	localparam logic [1:0] USE_RET = 2'h2;
	localparam logic [1:0] USE_ALT = 2'h3;

	// Control register bits.
	localparam int CTL_DUMP_BIT = 0;
	localparam int CTL_LOAD_CLR_BIT = 1;

	// Sweep memory word layout.
	localparam int RET_LSB = 14;
	localparam int RET_W = 10;
	localparam int MASS_LSB = 0;
	localparam int MASS_W = 12;

	// Frame timing in pulses.
	localparam int AUTO_DUMP_SEC = 256;
	localparam int ALT_USE_SEC = 8;
	localparam logic [1:0] CYC_STEPS = 2'h3;

	// Housekeeping multiplexer positions, counted from zero.
	localparam logic [HK_W-1:0] HK_LAST_STATUS = 4'h3;
	localparam logic [HK_W-1:0] HK_SPARE = 4'hf;
	localparam int ADC_W = 12;

	typedef enum logic [4:0] {
		MODE_LOAD = 5'b00001,
		MODE_DUMP = 5'b00010,
		MODE_RPA = 5'b00100,
		MODE_CYCLIC = 5'b01000,
		MODE_MASS = 5'b10000
	} mode_e;
endpackage

// File: sim/tb_tlm_mode_selector.sv
/* Bench for the selector with a formatter model.
   Assumes short frames: 16 clocks a quarter, 16 frames a second. */
`timescale 1ns/1ps
module tb_tlm_mode_selector
	import tlm_pkg::*;
;
	logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hrdy, pps_pin = 0, mfm_pin = 0, qfr_pin = 0;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [9:0] w [10], d_q, cd, fc = '0;
	logic [23:0] f_q, cf;
	logic [7:0] hk;
	logic [4:0] mode;
	logic ld, cal, dact, cyc, rf, mf;
	logic [9:0] rs;
	logic [11:0] ms;
	int err_total = 0, checks = 0, nps = 0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		fc <= fc + 10'h1;
		qfr_pin <= fc[3:0] < 4'h4;
		mfm_pin <= fc[5:0] < 6'h4;
		pps_pin <= fc < 10'h4;
		if (fc == 10'h3ff)
			nps <= nps + 1;
	end
	tlm_mode_selector #(.AUTO_DUMP_SECONDS(16)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hrdy),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hrdy), .hresp(), .pps_pin(pps_pin),
		.mfm_pin(mfm_pin), .qfr_pin(qfr_pin), .radial_low_mass_word(w[0]),
		.radial_high_mass_word(w[1]), .plus_z_low_mass_word(w[2]), .plus_z_high_mass_word(w[3]),
		.minus_z_low_mass_word(w[4]), .minus_z_high_mass_word(w[5]),
		.radial_retarding_word(w[6]), .plus_z_retarding_word(w[7]),
		.minus_z_retarding_word(w[8]), .background_counts(w[9]), .status_bits(32'h44332211),
		.adc_sample(12'hab5), .housekeeping_status_word(hk), .chan_a_load(), .chan_b_word(),
		.chan_c_word(), .chan_d_word(cd), .chan_e_word(), .chan_f_word(cf), .chan_load(ld),
		.calibrate(cal), .retarding_step(rs), .mass_step(ms), .retarding_from_mem(rf),
		.mass_from_mem(mf), .mode(mode), .dump_active(dact), .cyclic_active(cyc));
	tlm_fmt fmt (.clk(clk), .ld(ld), .d(cd), .f(cf), .d_q(d_q), .f_q(f_q));
	task summarize;
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task cmp(input string s, input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	// A negative count waits for bus ready, otherwise for that clock count within the second.
	task wt(input int k);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((k < 0 ? hrdy !== 1'b1 : fc != 10'(k)) && n < 1100);
		if (n >= 1100) begin
			err_total++;
			summarize();
		end
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		wt(-1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt(-1);
		rd = hrdata;
	endtask
	task t_hk;
		xfer(0, OFS_STATUS, '0);
		cmp("st", rd[4:0], MODE_MASS);
		wt(29);
		cmp("f", f_q, w[6]);
		for (int i = 0; i < 16; i++) begin
			wt(64 * i + 20);
			cmp("hk", hk, i < 4 ? 8'(32'h44332211 >> (8 * i)) : i < 15 ? 8'hab : 8'h0);
		end
	endtask
	task t_mass;
		xfer(1, OFS_MODE_A, 32'ha524);
		wt(1);
		wt(29);
		cmp("d", d_q, w[2]);
		cmp("f", f_q, w[7]);
		wt(541);
		cmp("d", d_q, w[3]);
		cmp("f", f_q, w[8]);
	endtask
	task t_rpa;
		xfer(1, OFS_MODE_A, 32'h80);
		xfer(0, OFS_MODE_A_ACT, '0);
		cmp("act", rd, 32'ha524);
		wt(1);
		wt(29);
		cmp("mode", mode, MODE_RPA);
		cmp("d", d_q, w[7]);
		cmp("f", f_q, w[6]);
	endtask
	task t_cyc;
		int dd [3] = '{2, 2, 4};
		xfer(1, OFS_MODE_A, 32'hf);
		wt(1);
		for (int k = 0; k < 4; k++) begin
			wt(64 * k + 29);
			cmp("f", f_q, w[6 + k % 3]);
			cmp("d", d_q, w[dd[k % 3]]);
		end
		cmp("cyc", cyc, 1'b1);
	endtask
	task t_load;
		for (int i = 0; i < 32; i++)
			xfer(1, OFS_MEM_LOAD, 32'h5a5a00 + i);
		@(posedge clk);
		cmp("cal", cal, 1'b1);
		wt(29);
		cmp("mode", mode, MODE_LOAD);
		cmp("f", f_q, w[9]);
		xfer(1, OFS_CONTROL, 32'h2);
		@(posedge clk);
		cmp("cal", cal, 1'b0);
	endtask
	task t_dump;
		xfer(1, OFS_CONTROL, 32'h1);
		wt(1);
		wt(29);
		cmp("dact", dact, 1'b1);
		cmp("f", f_q, 32'h5a5a00);
		cmp("step", {rs, ms}, {10'(24'h5a5a00 >> RET_LSB), 12'(24'h5a5a00 >> MASS_LSB)});
		cmp("use", {rf, mf}, 2'h3);
		wt(93);
		cmp("f", f_q, 32'h5a5a01);
		wt(29);
		cmp("f", f_q, 32'h5a5a10);
		wt(989);
		cmp("f", f_q, 32'h5a5a1f);
		wt(29);
		cmp("dact", dact, 1'b0);
	endtask
	task t_auto;
		int n;
		n = 0;
		while (dact !== 1'b1 && n < 20) begin
			wt(29);
			n++;
		end
		cmp("auto", nps == 16 || nps == 17, 1'b1);
	endtask
	initial begin
		for (int i = 0; i < 10; i++)
			w[i] = 10'h100 + 10'(i);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_hk();
		t_mass();
		t_rpa();
		t_cyc();
		t_load();
		t_dump();
		t_auto();
		summarize();
	end
endmodule

// File: sim/tlm_fmt.sv
/* Formatter model: copies channels D and F one clock after each load strobe.
   Assumes the strobe lasts one clock and the words change at the edge that ends it. */
`timescale 1ns/1ps
module tlm_fmt (
	input wire logic clk,
	input wire logic ld,
	input wire logic [9:0] d,
	input wire logic [23:0] f,
	output logic [9:0] d_q,
	output logic [23:0] f_q
);
	logic ld_ff = 1'b0;
	always @(posedge clk) begin
		ld_ff <= ld;
		if (ld_ff) begin
			d_q <= d;
			f_q <= f;
		end
	end
endmodule

// File: sim/tlm_sel_asserts.sv
/* Checker on the selector's ports.
   Assumes the bench holds every data word steady. */
`timescale 1ns/1ps
module tlm_sel_chk
	import tlm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chan_load,
	input wire logic calibrate,
	input wire logic dump_active,
	input wire logic [4:0] mode,
	input wire logic [9:0] chan_b_word,
	input wire logic [9:0] chan_d_word,
	input wire logic [23:0] chan_f_word,
	input wire logic [9:0] radial_low_mass_word,
	input wire logic [9:0] plus_z_retarding_word,
	input wire logic [9:0] radial_retarding_word,
	input wire logic [9:0] background_counts
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	mode_onehot_a: assert property ($onehot(mode)) else $error("mode");
	load_first_a: assert property (calibrate |-> ##[0:2] mode == MODE_LOAD)
		else $error("load");
	dump_next_a: assert property (dump_active && !calibrate |-> ##[0:2] mode == MODE_DUMP)
		else $error("dump");
	dump_end_a: assert property ($fell(dump_active) |-> ##[0:2] mode != MODE_DUMP)
		else $error("dump end");
	dump_hold_a: assert property ($rose(dump_active) |=> dump_active [*8])
		else $error("dump short");
	rpa_route_a: assert property (chan_load && mode == MODE_RPA |=>
		chan_d_word == plus_z_retarding_word && chan_f_word == {14'h0, radial_retarding_word})
		else $error("rpa");
	load_route_a: assert property (chan_load && calibrate && $past(calibrate, 8) |=>
		chan_f_word == {14'h0, background_counts}) else $error("bkg");
	b_route_a: assert property (chan_load |=> chan_b_word == radial_low_mass_word)
		else $error("chan b");
endmodule
bind tlm_mode_selector tlm_sel_chk chk (.clk(clk), .rst_n(rst_n), .chan_load(chan_load),
	.calibrate(calibrate), .dump_active(dump_active), .mode(mode), .chan_b_word(chan_b_word),
	.chan_d_word(chan_d_word), .chan_f_word(chan_f_word),
	.radial_low_mass_word(radial_low_mass_word), .plus_z_retarding_word(plus_z_retarding_word),
	.radial_retarding_word(radial_retarding_word), .background_counts(background_counts));
